// ===== rtl/tap_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tap_ctrl (
    // Clock and reset
    input  wire logic                      CLK_IN,
    input  wire logic                      NRST_IN,
    // Tester link pins
    input  wire logic                      TCK_IN,
    input  wire logic                      TMS_IN,
    input  wire logic                      TDI_IN,
    output logic                           TDO_OUT,
    output logic                           TDO_OE_OUT,
    // Boundary cells
    input  wire logic [tap_pkg::BSR_W-1:0] PINS_IN,
    output logic [tap_pkg::BSR_W-1:0]      BSR_PAR_OUT,
    output logic                           TEST_MODE_OUT,
    // Observation
    output logic [15:0]                    STATE_OUT,
    output logic [tap_pkg::IR_W-1:0]       INSTR_OUT
);

    // Whole module state
    typedef struct packed {
        tap_pkg::tap_state_t          state;
        logic [tap_pkg::IR_W-1:0]     ir_sh;
        logic [tap_pkg::IR_W-1:0]     ir;
        logic [tap_pkg::BSR_W-1:0]    bsr_sh;
        logic [tap_pkg::BSR_W-1:0]    bsr_par;
        logic [tap_pkg::ID_W-1:0]     id_sh;
        logic                         byp;
        tap_pkg::tdo_t                tdo;
        logic                         test_mode;
        logic [tap_pkg::BSR_W-1:0]    pins_s1;
        logic [tap_pkg::BSR_W-1:0]    pins_s2;
    } tap_t;

    tap_t             st_r;
    tap_t             st_nxt;
    tap_pkg::link_t   link;

    // Two-flop synchroniser and TCK edge finder
    tap_link_sync u_sync (
        .clk_in   (CLK_IN),
        .nrst_in  (NRST_IN),
        .tck_in   (TCK_IN),
        .tms_in   (TMS_IN),
        .tdi_in   (TDI_IN),
        .link_out (link)
    );

    // Instruction decode helpers
    logic sel_bsr;
    logic sel_id;
    logic sel_byp;
    logic ser_dr;

    // Unknown codes fall back to the one-stage bypass path
    always_comb begin
        sel_bsr = (st_r.ir == tap_pkg::INS_EXTEST) || (st_r.ir == tap_pkg::INS_SAMPLE);
        sel_id  = (st_r.ir == tap_pkg::INS_IDCODE);
        sel_byp = !sel_bsr && !sel_id;
        if (sel_bsr) begin
            ser_dr = st_r.bsr_sh[0];
        end else if (sel_id) begin
            ser_dr = st_r.id_sh[0];
        end else begin
            ser_dr = st_r.byp;
        end
    end

    // Next state: rising TCK steps the machine, falling TCK moves outputs
    always_comb begin
        st_nxt = st_r;
        // Pins are asynchronous; two flops keep a metastable level out of capture
        st_nxt.pins_s1 = PINS_IN;
        st_nxt.pins_s2 = st_r.pins_s1;
        if (link.rise) begin
            case (st_r.state)
                tap_pkg::ST_RESET: begin
                    // Holding TMS high here keeps reset; five highs land here
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_RESET;
                    end else begin
                        st_nxt.state = tap_pkg::ST_IDLE;
                    end
                end
                tap_pkg::ST_IDLE: begin
                    // Rest between scans; every register keeps its contents
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_SEL_DR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_IDLE;
                    end
                end
                tap_pkg::ST_SEL_DR: begin
                    // Start a data scan or step on toward the instruction column
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_SEL_IR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_CAP_DR;
                    end
                end
                tap_pkg::ST_CAP_DR: begin
                    // The boundary register captures the pins; the identify and bypass registers load fixed values
                    if (sel_bsr) begin
                        st_nxt.bsr_sh = st_r.pins_s2;
                    end else if (sel_id) begin
                        st_nxt.id_sh = tap_pkg::ID_VALUE;
                    end else if (sel_byp) begin
                        st_nxt.byp = 1'b0;
                    end
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_EX1_DR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_SH_DR;
                    end
                end
                tap_pkg::ST_SH_DR: begin
                    // Only the selected register moves, the rest hold
                    if (sel_bsr) begin
                        st_nxt.bsr_sh = {link.tdi, st_r.bsr_sh[tap_pkg::BSR_W-1:1]};
                    end else if (sel_id) begin
                        st_nxt.id_sh = {link.tdi, st_r.id_sh[tap_pkg::ID_W-1:1]};
                    end else if (sel_byp) begin
                        st_nxt.byp = link.tdi;
                    end
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_EX1_DR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_SH_DR;
                    end
                end
                tap_pkg::ST_EX1_DR: begin
                    // Finish the scan or park it in pause
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_UPD_DR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_PAU_DR;
                    end
                end
                tap_pkg::ST_PAU_DR: begin
                    // Shift stages hold while the tester is busy elsewhere
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_EX2_DR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_PAU_DR;
                    end
                end
                tap_pkg::ST_EX2_DR: begin
                    // Resume shifting or finish the scan
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_UPD_DR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_SH_DR;
                    end
                end
                tap_pkg::ST_UPD_DR: begin
                    // Chain straight into another scan or rest in idle
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_SEL_DR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_IDLE;
                    end
                end
                tap_pkg::ST_SEL_IR: begin
                    // A further high gives up and returns to reset
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_RESET;
                    end else begin
                        st_nxt.state = tap_pkg::ST_CAP_IR;
                    end
                end
                tap_pkg::ST_CAP_IR: begin
                    // Fixed pattern lets the tester spot a broken chain
                    st_nxt.ir_sh = tap_pkg::IR_CAPTURE_VAL;
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_EX1_IR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_SH_IR;
                    end
                end
                tap_pkg::ST_SH_IR: begin
                    // Instruction stages move one place toward TDO
                    st_nxt.ir_sh = {link.tdi, st_r.ir_sh[tap_pkg::IR_W-1:1]};
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_EX1_IR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_SH_IR;
                    end
                end
                tap_pkg::ST_EX1_IR: begin
                    // Finish the instruction scan or park it
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_UPD_IR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_PAU_IR;
                    end
                end
                tap_pkg::ST_PAU_IR: begin
                    // Instruction stages hold while parked
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_EX2_IR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_PAU_IR;
                    end
                end
                tap_pkg::ST_EX2_IR: begin
                    // Resume instruction shifting or finish
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_UPD_IR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_SH_IR;
                    end
                end
                tap_pkg::ST_UPD_IR: begin
                    // Chain straight into a data scan or rest in idle
                    if (link.tms) begin
                        st_nxt.state = tap_pkg::ST_SEL_DR;
                    end else begin
                        st_nxt.state = tap_pkg::ST_IDLE;
                    end
                end
                default: begin
                    // An illegal code can only come from an upset; recover via reset
                    st_nxt.state = tap_pkg::ST_RESET;
                end
            endcase
        end
        // Falling-edge actions use the state reached at the previous rise
        if (link.fall) begin
            // Boundary output moves only here, so driven pins stay steady while shifting
            if (st_r.state == tap_pkg::ST_UPD_DR && sel_bsr) begin
                st_nxt.bsr_par = st_r.bsr_sh;
            end
            // New instruction takes effect only once the scan is complete
            if (st_r.state == tap_pkg::ST_UPD_IR) begin
                st_nxt.ir = st_r.ir_sh;
            end
            // TDO changes on the fall so the tester samples it stable on the rise
            if (st_r.state == tap_pkg::ST_SH_DR) begin
                st_nxt.tdo.tdo    = ser_dr;
                st_nxt.tdo.tdo_oe = 1'b1;
            end else if (st_r.state == tap_pkg::ST_SH_IR) begin
                st_nxt.tdo.tdo    = st_r.ir_sh[0];
                st_nxt.tdo.tdo_oe = 1'b1;
            end else begin
                st_nxt.tdo.tdo_oe = 1'b0;
            end
        end
        // Reset state: instruction back to identify code, test logic idle
        if (st_r.state == tap_pkg::ST_RESET) begin
            st_nxt.ir = tap_pkg::INS_IDCODE;
        end
        // Pins handed to boundary cells only under EXTEST; reset forces normal mode
        st_nxt.test_mode = (st_nxt.state != tap_pkg::ST_RESET)
                           && (st_nxt.ir == tap_pkg::INS_EXTEST);
    end

    // Reset lands in Test-Logic-Reset with the identify instruction active
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st_r       <= '0;
            st_r.state <= tap_pkg::ST_RESET;
            st_r.ir    <= tap_pkg::INS_IDCODE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state flops
    always_comb begin
        TDO_OUT       = st_r.tdo.tdo;
        TDO_OE_OUT    = st_r.tdo.tdo_oe;
        BSR_PAR_OUT   = st_r.bsr_par;
        TEST_MODE_OUT = st_r.test_mode;
        STATE_OUT     = st_r.state;
        INSTR_OUT     = st_r.ir;
    end

endmodule // tap_ctrl
`default_nettype wire

// ===== include/tap_pkg.sv
package tap_pkg;

    // Instruction register geometry and fixed capture pattern
    localparam int          IR_W           = 3;
    localparam logic [2:0]  IR_CAPTURE_VAL = 3'h4;

    // Instruction codes; the identify code is also the reset instruction
    localparam logic [2:0]  INS_EXTEST     = 3'h0;
    localparam logic [2:0]  INS_SAMPLE     = 3'h1;
    localparam logic [2:0]  INS_IDCODE     = 3'h2;
    localparam logic [2:0]  INS_BYPASS     = 3'h7;

    // Test data register widths
    localparam int          BSR_W          = 8;
    localparam int          ID_W           = 32;

    // Identification word; the value is arbitrary
    localparam logic [31:0] ID_VALUE       = 32'h0000_1001;

    // Consecutive TMS-high edges that force the reset state
    localparam int          TMS_RESET_CNT  = 5;

    // Sixteen controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET   = 16'h0001,
        ST_IDLE    = 16'h0002,
        ST_SEL_DR  = 16'h0004,
        ST_CAP_DR  = 16'h0008,
        ST_SH_DR   = 16'h0010,
        ST_EX1_DR  = 16'h0020,
        ST_PAU_DR  = 16'h0040,
        ST_EX2_DR  = 16'h0080,
        ST_UPD_DR  = 16'h0100,
        ST_SEL_IR  = 16'h0200,
        ST_CAP_IR  = 16'h0400,
        ST_SH_IR   = 16'h0800,
        ST_EX1_IR  = 16'h1000,
        ST_PAU_IR  = 16'h2000,
        ST_EX2_IR  = 16'h4000,
        ST_UPD_IR  = 16'h8000
    } tap_state_t;

    // Synchronised link pins and their edge events
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic rise;
        logic fall;
    } link_t;

    // Serial output pin with its enable
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } tdo_t;

endpackage

// ===== rtl/tap_link_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Brings the tester's pins into the CLK_IN domain and finds TCK edges
module tap_link_sync (
    input  wire logic           clk_in,
    input  wire logic           nrst_in,
    input  wire logic           tck_in,
    input  wire logic           tms_in,
    input  wire logic           tdi_in,
    output var  tap_pkg::link_t link_out
);

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic       tck_d;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = {tck_in, tms_in, tdi_in};
        st_nxt.s2    = st_r.s1;
        st_nxt.tck_d = st_r.s2[2];
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Edge pulses are one CLK_IN cycle wide
    always_comb begin
        link_out.tck  = st_r.s2[2];
        link_out.tms  = st_r.s2[1];
        link_out.tdi  = st_r.s2[0];
        link_out.rise = st_r.s2[2] & ~st_r.tck_d;
        link_out.fall = ~st_r.s2[2] & st_r.tck_d;
    end

endmodule // tap_link_sync
`default_nettype wire

// ===== test/tap_tester.sv
`timescale 1ns/1ps
`default_nettype none
// Tester model: TCK rests low between steps, pins move only while it is low
module tap_tester (
    // Clock and returned data
    input  wire logic clk_in,
    input  wire logic tdo_in,
    // Link pins
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    // Park with TMS high so a fresh device heads for reset
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // One 80 ns period; TDO is read just before the rise that shifts it
    task automatic step(input logic m, input logic di, output logic o);
        @(negedge clk_in);
        tms_out = m;
        tdi_out = di;
        repeat (3) @(negedge clk_in);
        o = tdo_in;
        tck_out = 1'b1;
        repeat (4) @(negedge clk_in);
        tck_out = 1'b0;
    endtask
endmodule // tap_tester
`default_nettype wire

// ===== test/tap_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Outputs follow a TCK edge by 2-3 clocks, so two clocks back shows that edge
module tap_ctrl_sva (
    // Clock, reset and link
    input wire logic                      CLK_IN,
    input wire logic                      NRST_IN,
    input wire logic                      TCK_IN,
    input wire logic                      TMS_IN,
    input wire logic                      TDO_OUT,
    input wire logic                      TDO_OE_OUT,
    // Observed outputs
    input wire logic [tap_pkg::BSR_W-1:0] BSR_PAR_OUT,
    input wire logic                      TEST_MODE_OUT,
    input wire logic [15:0]               STATE_OUT,
    input wire logic [tap_pkg::IR_W-1:0]  INSTR_OUT
);
    logic       tck_d_r;
    logic       rise;
    logic [2:0] hi_r;
    assign rise = TCK_IN && !tck_d_r;
    // Run of TMS-high rises, saturating so long resets never wrap
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            tck_d_r <= 1'b0;
            hi_r    <= 3'h0;
        end else begin
            tck_d_r <= TCK_IN;
            if (rise) hi_r <= !TMS_IN ? 3'h0 : (hi_r < 3'h5) ? hi_r + 3'h1 : hi_r;
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    a_one_hot: assert property ($onehot(STATE_OUT))
        else $error("state not one-hot");
    a_state_on_rise: assert property ($changed(STATE_OUT) |-> $past(TCK_IN, 2))
        else $error("state moved without TCK rise");
    a_five_high: assert property (rise && TMS_IN && hi_r > 3'h3 |->
        ##[1:6] STATE_OUT == tap_pkg::ST_RESET) else $error("no reset after five highs");
    a_reset_instr: assert property ((STATE_OUT == tap_pkg::ST_RESET) [*2] |->
        INSTR_OUT == tap_pkg::INS_IDCODE && !TEST_MODE_OUT) else $error("reset not idle");
    a_idle_hold: assert property (STATE_OUT == tap_pkg::ST_IDLE && rise && !TMS_IN
        |=> (STATE_OUT == tap_pkg::ST_IDLE) [*6]) else $error("idle not held");
    a_instr_update: assert property ($changed(INSTR_OUT) && STATE_OUT != tap_pkg::ST_RESET
        |-> STATE_OUT == tap_pkg::ST_UPD_IR && !$past(TCK_IN, 2)) else $error("stray instr");
    a_bsr_update: assert property ($changed(BSR_PAR_OUT) |->
        STATE_OUT == tap_pkg::ST_UPD_DR && !$past(TCK_IN, 2)) else $error("stray bsr load");
    a_oe_shift: assert property ($rose(TDO_OE_OUT) |-> !$past(TCK_IN, 2) &&
        STATE_OUT inside {tap_pkg::ST_SH_DR, tap_pkg::ST_SH_IR}) else $error("oe outside shift");
    a_oe_drop: assert property ($fell(TDO_OE_OUT) |->
        !(STATE_OUT inside {tap_pkg::ST_SH_DR, tap_pkg::ST_SH_IR})) else $error("oe dropped early");
    a_tdo_fall: assert property (TDO_OE_OUT && $changed(TDO_OUT) |-> !$past(TCK_IN, 2))
        else $error("tdo moved off falling edge");
    c_pause_ir: cover property (STATE_OUT == tap_pkg::ST_PAU_IR);
    c_bsr_load: cover property ($changed(BSR_PAR_OUT));
    c_test_mode: cover property ($rose(TEST_MODE_OUT));
endmodule // tap_ctrl_sva
bind tap_ctrl tap_ctrl_sva i_tap_ctrl_sva (
    .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .TCK_IN(TCK_IN), .TMS_IN(TMS_IN),
    .TDO_OUT(TDO_OUT), .TDO_OE_OUT(TDO_OE_OUT), .BSR_PAR_OUT(BSR_PAR_OUT),
    .TEST_MODE_OUT(TEST_MODE_OUT), .STATE_OUT(STATE_OUT), .INSTR_OUT(INSTR_OUT)
);
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                      clk, nrst, tck, tms, tdi, tdo, tdo_oe, test_mode, t;
    logic [tap_pkg::BSR_W-1:0] pins, bsr_par, bsr_exp;
    logic [15:0]               state;
    logic [2:0]                instr, ins;
    logic [31:0]               d, din;
    int                        bad_count, n_tests, si;
    int                        cyc = 0;
    // Next state index per state bit, for TMS low and TMS high
    byte n0 [16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
    byte n1 [16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
    logic [2:0] codes [4] = '{tap_pkg::INS_EXTEST, tap_pkg::INS_SAMPLE,
                              tap_pkg::INS_IDCODE, tap_pkg::INS_BYPASS};
    tap_ctrl i_tap_ctrl (
        .CLK_IN(clk), .NRST_IN(nrst), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi),
        .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe), .PINS_IN(pins), .BSR_PAR_OUT(bsr_par),
        .TEST_MODE_OUT(test_mode), .STATE_OUT(state), .INSTR_OUT(instr)
    );
    tap_tester i_tap_tester (
        .clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask
    // Bypass captures 0 and delays data by one stage; boundary cells see the pins
    function automatic logic [7:0] dr_exp(input logic [2:0] c, input logic [7:0] p,
                                          input logic [7:0] di);
        if (c == tap_pkg::INS_EXTEST || c == tap_pkg::INS_SAMPLE) return p;
        if (c == tap_pkg::INS_IDCODE) return tap_pkg::ID_VALUE[7:0];
        return {di[6:0], 1'b0};
    endfunction
    // One TCK step with the controller graph followed alongside
    task automatic go(input logic m, input logic di, output logic o);
        si = m ? n1[si] : n0[si];
        i_tap_tester.step(m, di, o);
        chk("state", 32'h1 << si, 32'(state));
    endtask
    // Full scan from idle back to idle, parking in pause after bit pau
    task automatic scan(input logic ir, input int n, input logic [31:0] di, input int pau,
                        output logic [31:0] q);
        logic o;
        q = '0;
        go(1'b1, 1'b0, o);
        if (ir) go(1'b1, 1'b0, o);
        go(1'b0, 1'b0, o);
        go(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            go(i == n - 1 || i == pau, di[i], o);
            q[i] = o;
            chk("oe", 32'h1, 32'(tdo_oe));
            if (i == pau) begin
                go(1'b0, 1'b0, o);
                go(1'b0, 1'b0, o);
                go(1'b1, 1'b0, o);
                go(1'b0, 1'b0, o);
            end
        end
        go(1'b1, 1'b0, o);
        go(1'b0, 1'b0, o);
        chk("oe", 32'h0, 32'(tdo_oe));
    endtask
    // A hang is cut off far beyond the expected 3000 or so cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        nrst = 1'b0;
        pins = '0;
        bad_count = 0;
        n_tests = 0;
        si = 0;
        bsr_exp = '0;
        void'($urandom(32'h415A));
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chk("instr", 32'(tap_pkg::INS_IDCODE), 32'(instr));
        chk("oe", 32'h0, 32'(tdo_oe));
        repeat (5) go(1'b1, 1'b1, t);
        go(1'b0, 1'b0, t);
        go(1'b0, 1'b0, t);
        scan(1'b0, 32, $urandom, $urandom % 31, d);
        chk("idcode", tap_pkg::ID_VALUE, d);
        foreach (codes[k]) begin
            ins = codes[k];
            scan(1'b1, 3, 32'(ins), $urandom % 2, d);
            chk("ir capture", 32'(tap_pkg::IR_CAPTURE_VAL), 32'(d[2:0]));
            chk("instr", 32'(ins), 32'(instr));
            chk("test mode", 32'(ins == tap_pkg::INS_EXTEST), 32'(test_mode));
            din = $urandom;
            pins = din[15:8];
            scan(1'b0, 8, din, $urandom % 7, d);
            chk("dr out", 32'(dr_exp(ins, pins, din[7:0])), 32'(d[7:0]));
            if (ins == tap_pkg::INS_EXTEST || ins == tap_pkg::INS_SAMPLE) bsr_exp = din[7:0];
            chk("bsr", 32'(bsr_exp), 32'(bsr_par));
            chk("instr hold", 32'(ins), 32'(instr));
        end
        repeat (200) go(1'($urandom), 1'($urandom), t);
        repeat (5) go(1'b1, 1'b0, t);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
